// ---- rtl/accel_pm_params.svh ----
// Constants for the power-mode and data-rate controller.
// Notes on behaviour
// - Start in standby; measure needs I/O supply.
// - Measure bit set enters measurement mode.
// - Standby accepts reads and writes; writes only to addresses below 0x40.
// - Measure bit cleared returns to standby.
// - No sensing activity while in standby.
// - Low-power bit selects reduced-power operation.
// - Low power lowers the internal sampling rate for rate codes 7 to C only.
// - Rate code picks rate; each step halves.
// - Standby entry keeps stored data intact.
`ifndef ACCEL_PM_PARAMS_SVH
`define ACCEL_PM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define BANDWIDTH_RATE_CTRL_ADDR 8'h2C
`define POWER_CONTROL_ADDR       8'h2D
`define REG_SPACE_WORDS          64
`define BANDWIDTH_RATE_RESET     8'h0A
`define POWER_CONTROL_RESET      8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MEASURE_BIT         3
`define LOW_POWER_BIT       4
`define RATE_CODE_MSB       3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLOCK_HZ            25000000
`define TOP_RATE_HZ         3200
`define TOP_RATE_CODE       4'hF
`define LP_CODE_MIN         4'h7
`define LP_CODE_MAX         4'hC
`define NORM_OSR_LOG2       2'd2
`define LP_OSR_LOG2         2'd0

`endif

// ---- rtl/accel_pm_pkg.sv ----
// Types shared by the power-mode controller and its register store.
`default_nettype none
package accel_pm_pkg;
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'b01,
		MODE_MEASURE = 2'b10
	} mode_type;
	typedef logic [7:0] byte_type;
	typedef logic [5:0] reg_index_type;
endpackage
`default_nettype wire

// ---- rtl/reg_store_if.sv ----
// Carrier between the controller and its register storage.
`timescale 1ns/1ps
`default_nettype none
interface reg_store_if;
	import accel_pm_pkg::*;
	logic          wr;
	reg_index_type idx;
	byte_type      wdata;
	byte_type      rdata;
	modport ctrl  (output wr, output idx, output wdata, input rdata);
	modport store (input wr, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- rtl/reg_store.sv ----
// Flip-flop storage for the whole register space, with reset defaults.
`timescale 1ns/1ps
`default_nettype none
`include "accel_pm_params.svh"
module reg_store #(
	parameter int WORDS = `REG_SPACE_WORDS
) (
	input  wire logic   clock_in,
	input  wire logic   srst_in,
	reg_store_if.store  bus
);
	import accel_pm_pkg::*;

	// Storage is indexed by the low six address bits, so the depth must
	// cover that whole space exactly.
	if (WORDS != `REG_SPACE_WORDS) begin : g_chk
		$error("WORDS must equal the register space size");
	end

	byte_type mem_reg  [WORDS];
	byte_type mem_next [WORDS];

	// Reset value of a word; only the rate control register resets to a nonzero value.
	function automatic byte_type reset_value(input int i);
		if (i == int'(`BANDWIDTH_RATE_CTRL_ADDR))
			return `BANDWIDTH_RATE_RESET;
		if (i == int'(`POWER_CONTROL_ADDR))
			return `POWER_CONTROL_RESET;
		return 8'h00;
	endfunction

	// Mode changes never touch storage, so data survives standby entry.
	always_comb begin
		mem_next = mem_reg;
		if (bus.wr)
			mem_next[bus.idx] = bus.wdata;
	end

	// Storage registers.
	always_ff @(posedge clock_in) begin
		for (int i = 0; i < WORDS; i++) begin
			if (srst_in)
				mem_reg[i] <= reset_value(i);
			else
				mem_reg[i] <= mem_next[i];
		end
	end

	assign bus.rdata = mem_reg[bus.idx];
endmodule
`default_nettype wire

// ---- rtl/accel_power_mode_rate_ctrl.sv ----
// Standby/measurement mode control and output-data-rate scheduler.
`timescale 1ns/1ps
`default_nettype none
`include "accel_pm_params.svh"
module accel_power_mode_rate_ctrl #(
	parameter int BASE_PERIOD_CYCLES = `CLOCK_HZ / `TOP_RATE_HZ,
	parameter int CNT_W              = 28
) (
	input  wire logic                 clock_in,
	input  wire logic                 srst_in,
	input  wire logic                 io_supply_ok_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	input  wire logic [7:0]           reg_addr_in,
	input  wire accel_pm_pkg::byte_type reg_wdata_in,
	output var  accel_pm_pkg::byte_type reg_rdata_out,
	output logic                      reg_rdata_valid_out,
	output logic                      measure_active_out,
	output logic                      low_power_out,
	output logic [3:0]                rate_code_out,
	output logic                      convert_tick_out,
	output logic                      sample_tick_out
);
	import accel_pm_pkg::*;

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	// The slowest rate is the base period shifted left fifteen times.
	if (BASE_PERIOD_CYCLES < 8 || CNT_W > 31 ||
	    (longint'(BASE_PERIOD_CYCLES) << 15) >= (64'd1 << CNT_W)) begin : g_chk
		$error("BASE_PERIOD_CYCLES or CNT_W out of range");
	end

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------
	// Low power only pays inside the mid-rate band; elsewhere the
	// scheduler keeps the normal internal rate.
	function automatic logic lp_benefit(input logic [3:0] code,
	                                     input logic lp);
		return lp && code >= `LP_CODE_MIN && code <= `LP_CODE_MAX;
	endfunction

	function automatic logic [1:0] osr_log2(input logic [3:0] code,
	                                        input logic lp);
		return lp_benefit(code, lp) ? `LP_OSR_LOG2 : `NORM_OSR_LOG2;
	endfunction

	// Cycles between internal conversions: each code step halves the rate, except a step into or out of the band 7 to C with low power set.
	function automatic logic [CNT_W-1:0] conv_period(input logic [3:0] code,
	                                                 input logic lp);
		logic [CNT_W-1:0] full;
		full = CNT_W'(BASE_PERIOD_CYCLES) << (`TOP_RATE_CODE - code);
		return full >> osr_log2(code, lp);
	endfunction

	function automatic logic addr_hit(input logic [7:0] a);
		return a < 8'(`REG_SPACE_WORDS);
	endfunction

	// ------------------------------------------------------------------
	// Supply synchroniser
	// ------------------------------------------------------------------
	logic io_meta_reg;
	logic io_ok_reg;

	// The supply flag is asynchronous, so it passes two flops first.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			io_meta_reg <= 1'b0;
			io_ok_reg   <= 1'b0;
		end else begin
			io_meta_reg <= io_supply_ok_in;
			io_ok_reg   <= io_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------------
	reg_store_if st ();

	reg_store u_store (
		.clock_in (clock_in),
		.srst_in  (srst_in),
		.bus      (st.store)
	);

	logic     wr_ok;
	logic     pc_wr;
	logic     bw_wr;
	byte_type rdata_next;
	logic     rvalid_next;

	// Access is open in either mode; it is gated by the I/O supply, and writes also by the register address range.
	always_comb begin
		wr_ok       = reg_wr_in && io_ok_reg && addr_hit(reg_addr_in);
		pc_wr       = wr_ok && reg_addr_in == `POWER_CONTROL_ADDR;
		bw_wr       = wr_ok && reg_addr_in == `BANDWIDTH_RATE_CTRL_ADDR;
		st.wr       = wr_ok;
		st.idx      = reg_addr_in[5:0];
		st.wdata    = reg_wdata_in;
		rvalid_next = reg_rd_in && io_ok_reg;
		rdata_next  = addr_hit(reg_addr_in) ? st.rdata : 8'h00;
	end

	// Read answer registers; unmapped addresses read as zero.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			reg_rdata_out       <= 8'h00;
			reg_rdata_valid_out <= 1'b0;
		end else begin
			reg_rdata_out       <= rdata_next;
			reg_rdata_valid_out <= rvalid_next;
		end
	end

	// ------------------------------------------------------------------
	// Control copies and mode machine
	// ------------------------------------------------------------------
	mode_type   mode_reg;
	mode_type   mode_next;
	logic       meas_bit_reg;
	logic       meas_bit_next;
	logic       lp_next;
	logic [3:0] rate_next;

	// A measure bit stored while the supply is present is kept through a supply
	// loss and takes effect again once the supply returns; writes without supply are dropped.
	always_comb begin
		meas_bit_next = pc_wr ? reg_wdata_in[`MEASURE_BIT] : meas_bit_reg;
		lp_next       = bw_wr ? reg_wdata_in[`LOW_POWER_BIT] : low_power_out;
		rate_next     = bw_wr ? reg_wdata_in[`RATE_CODE_MSB:0]
		                      : rate_code_out;
		mode_next     = mode_reg;
		case (mode_reg)
			MODE_STANDBY: begin
				if (meas_bit_next && io_ok_reg)
					mode_next = MODE_MEASURE;
			end
			MODE_MEASURE: begin
				if (!(meas_bit_next && io_ok_reg))
					mode_next = MODE_STANDBY;
			end
			default: begin
				mode_next = MODE_STANDBY;
			end
		endcase
	end

	// Mode and control registers; reset lands in standby.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			mode_reg      <= MODE_STANDBY;
			meas_bit_reg  <= 1'b0;
			low_power_out <= 1'(`BANDWIDTH_RATE_RESET >> `LOW_POWER_BIT);
			rate_code_out <= 4'(`BANDWIDTH_RATE_RESET);
		end else begin
			mode_reg      <= mode_next;
			meas_bit_reg  <= meas_bit_next;
			low_power_out <= lp_next;
			rate_code_out <= rate_next;
		end
	end

	assign measure_active_out = mode_reg[1];

	// ------------------------------------------------------------------
	// Sampling scheduler
	// ------------------------------------------------------------------
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [1:0]       phase_reg;
	logic [1:0]       phase_next;
	logic [1:0]       phase_last;
	logic             conv_next;
	logic             samp_next;

	// A rate change restarts the period so no stale long count lingers.
	always_comb begin
		cnt_next   = cnt_reg;
		phase_next = phase_reg;
		conv_next  = 1'b0;
		samp_next  = 1'b0;
		phase_last = 2'((3'd1 << osr_log2(rate_code_out, low_power_out)) - 3'd1);
		if (mode_next != MODE_MEASURE) begin
			cnt_next   = '0;
			phase_next = 2'd0;
		end else if (mode_reg != MODE_MEASURE || bw_wr) begin
			cnt_next   = conv_period(rate_next, lp_next) - 1'b1;
			phase_next = 2'd0;
		end else if (cnt_reg == '0) begin
			cnt_next   = conv_period(rate_code_out, low_power_out) - 1'b1;
			conv_next  = 1'b1;
			samp_next  = phase_reg == phase_last;
			phase_next = samp_next ? 2'd0 : phase_reg + 2'd1;
		end else begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	// Scheduler registers.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			cnt_reg          <= '0;
			phase_reg        <= 2'd0;
			convert_tick_out <= 1'b0;
			sample_tick_out  <= 1'b0;
		end else begin
			cnt_reg          <= cnt_next;
			phase_reg        <= phase_next;
			convert_tick_out <= conv_next;
			sample_tick_out  <= samp_next;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);

	sequence s_pc_write(bit v);
		reg_wr_in && io_ok_reg && reg_addr_in == `POWER_CONTROL_ADDR &&
		reg_wdata_in[`MEASURE_BIT] == v;
	endsequence

	property p_reset_standby;
		$past(srst_in) |-> !measure_active_out && !sample_tick_out;
	endproperty
	a_reset_standby: assert property (p_reset_standby)
		else $error("not in standby after reset");

	property p_need_supply;
		!io_ok_reg |=> !measure_active_out;
	endproperty
	a_need_supply: assert property (p_need_supply)
		else $error("measuring without I/O supply");

	property p_enter;
		s_pc_write(1'b1) |=> measure_active_out;
	endproperty
	a_enter: assert property (p_enter)
		else $error("measure bit set did not enter measurement");

	property p_leave;
		s_pc_write(1'b0) |=> !measure_active_out ##1 !convert_tick_out;
	endproperty
	a_leave: assert property (p_leave)
		else $error("measure bit clear did not return to standby");

	property p_quiet_standby;
		!measure_active_out |-> !convert_tick_out && !sample_tick_out;
	endproperty
	a_quiet_standby: assert property (p_quiet_standby)
		else $error("sensing tick while in standby");

	property p_lp_write;
		bw_wr |=> low_power_out == $past(reg_wdata_in[`LOW_POWER_BIT]) &&
		          rate_code_out == $past(reg_wdata_in[3:0]);
	endproperty
	a_lp_write: assert property (p_lp_write)
		else $error("rate register write not applied");

	property p_lp_rate;
		convert_tick_out && lp_benefit(rate_code_out, low_power_out)
			|-> sample_tick_out;
	endproperty
	a_lp_rate: assert property (p_lp_rate)
		else $error("low power internal rate not reduced");

	property p_sample_on_conv;
		sample_tick_out |-> convert_tick_out;
	endproperty
	a_sample_on_conv: assert property (p_sample_on_conv)
		else $error("sample tick without conversion");

	property p_period_bound;
		measure_active_out |->
			cnt_reg < conv_period(rate_code_out, low_power_out);
	endproperty
	a_period_bound: assert property (p_period_bound)
		else $error("scheduler count beyond rate period");

	property p_readback;
		(wr_ok ##1 (reg_rd_in && io_ok_reg &&
		            reg_addr_in == $past(reg_addr_in) && !reg_wr_in))
			|=> reg_rdata_out == $past(reg_wdata_in, 2);
	endproperty
	a_readback: assert property (p_readback)
		else $error("register readback mismatch");
endmodule
`default_nettype wire

// ---- dv/host_model.sv ----
// Host-side model issuing single-byte register accesses and the I/O supply.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic              clock_in,
	output logic                   supply_out,
	output logic                   wr_out,
	output logic                   rd_out,
	output logic [7:0]             addr_out,
	output var accel_pm_pkg::byte_type wdata_out
);
	import accel_pm_pkg::*;

	// Idle bus at time zero; the I/O supply is present from the start.
	initial begin
		supply_out = 1'b1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end

	// One strobe cycle per access; address and data are inverted after
	// release so a stale value never looks like a qualified request.
	task automatic access(input logic w, input logic [7:0] a,
		input byte_type d);
		@(posedge clock_in);
		wr_out <= w;
		rd_out <= !w;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clock_in);
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask

	// Write followed at once by a read of the same address, so the read
	// must return the byte that the write has just stored.
	task automatic write_read(input logic [7:0] a, input byte_type d);
		@(posedge clock_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clock_in);
		wr_out <= 1'b0;
		rd_out <= 1'b1;
		@(posedge clock_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask

	// Supply changes are launched just after an edge like any other input.
	task automatic set_supply(input logic v);
		@(posedge clock_in);
		supply_out <= v;
	endtask
endmodule
`default_nettype wire

// ---- dv/accel_power_mode_rate_ctrl_tb.sv ----
// Self-checking bench for the power-mode and data-rate controller.
`timescale 1ns/1ps
`default_nettype none
module accel_power_mode_rate_ctrl_tb;
	import accel_pm_pkg::*;
	// A small base period keeps the slowest tested rate short.
	localparam int BASE = 8;
	logic       clock_in;
	logic       srst_in;
	wire logic  supply;
	wire logic  wr;
	wire logic  rd;
	wire logic [7:0] addr;
	byte_type   wdata;
	byte_type   rdata;
	logic       rvalid;
	logic       meas;
	logic       lp;
	logic [3:0] code;
	logic       conv;
	logic       samp;
	byte_type   exp_q[$];
	byte_type   mem[0:5];
	int         failures;
	int         checks;
	int         cycles;
	int         i;
	int         c;
	int         n;

	host_model host_model_inst (.clock_in(clock_in), .supply_out(supply),
		.wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

	accel_power_mode_rate_ctrl #(.BASE_PERIOD_CYCLES(BASE), .CNT_W(28))
		accel_power_mode_rate_ctrl_inst (.clock_in(clock_in),
		.srst_in(srst_in), .io_supply_ok_in(supply), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .reg_rdata_valid_out(rvalid),
		.measure_active_out(meas), .low_power_out(lp),
		.rate_code_out(code), .convert_tick_out(conv),
		.sample_tick_out(samp));

	// Clock at 25 MHz.
	always #20 clock_in = ~clock_in;

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic final_report;
		$display("Checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Reads note their expected byte first; the monitor pops it.
	task automatic rd_chk(input logic [7:0] a, input byte_type e);
		exp_q.push_back(e);
		host_model_inst.access(1'b0, a, 8'h00);
	endtask

	function automatic logic pick(input logic cv);
		return cv ? conv : samp;
	endfunction

	// Distance between two consecutive ticks; bounded so a dead
	// scheduler shows up as a wrong gap rather than a hang.
	task automatic gap(input logic cv, output int g);
		int k;
		k = 0;
		do begin @(negedge clock_in); k++; end
		while (pick(cv) !== 1'b1 && k < 2000);
		g = 0;
		do begin @(negedge clock_in); g++; end
		while (pick(cv) !== 1'b1 && g < 2000);
	endtask

	// Output watcher on the settled half of the cycle.
	always @(negedge clock_in) begin
		if (!srst_in && rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("ERROR read_valid expected 0 seen 1");
			end else begin
				chk("read_data", exp_q.pop_front(), rdata);
			end
		end
		if (!srst_in && (conv | samp) !== 1'b0 && meas !== 1'b1) begin
			failures++;
			$display("ERROR standby_tick expected 0 seen 1");
		end
	end

	// A hang is cut short well beyond the several hundred cycles needed.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		clock_in = 1'b0;
		srst_in = 1'b1;
		failures = 0;
		checks = 0;
		cycles = 0;
		void'($urandom(14932));
		repeat (8) @(posedge clock_in);
		srst_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		@(negedge clock_in);
		chk("measure_active", 0, meas);
		chk("rate_code", 4'hA, code);
		rd_chk(8'h2C, 8'h0A);
		rd_chk(8'h2D, 8'h00);
		for (i = 0; i < 6; i++) begin
			mem[i] = byte_type'($urandom);
			host_model_inst.access(1'b1, 8'(i * 6), mem[i]);
		end
		for (i = 0; i < 6; i++) rd_chk(8'(i * 6), mem[i]);
		mem[5] = byte_type'($urandom);
		exp_q.push_back(mem[5]);
		host_model_inst.write_read(8'h1E, mem[5]);
		host_model_inst.access(1'b1, 8'h45, 8'hFF);
		rd_chk(8'h45, 8'h00);
		// Rate is configured before measurement is switched on.
		host_model_inst.access(1'b1, 8'h2C, 8'h0F);
		host_model_inst.access(1'b1, 8'h2D, 8'h08);
		@(negedge clock_in);
		chk("measure_active", 1, meas);
		for (c = 15; c >= 12; c--) begin
			host_model_inst.access(1'b1, 8'h2C, {4'h0, c[3:0]});
			@(negedge clock_in);
			chk("rate_code", c, code);
			gap(1'b1, n);
			chk("convert_gap", (BASE << (15 - c)) >> 2, n);
			gap(1'b0, n);
			chk("sample_gap", BASE << (15 - c), n);
		end
		host_model_inst.access(1'b1, 8'h2C, 8'h1C);
		@(negedge clock_in);
		chk("low_power", 1, lp);
		gap(1'b1, n);
		chk("lp_convert_gap", BASE << 3, n);
		gap(1'b0, n);
		chk("lp_sample_gap", BASE << 3, n);
		// Low power at the top code gains nothing: normal timing stays.
		host_model_inst.access(1'b1, 8'h2C, 8'h1F);
		@(negedge clock_in);
		chk("low_power", 1, lp);
		gap(1'b1, n);
		chk("lp_fast_convert_gap", BASE >> 2, n);
		gap(1'b0, n);
		chk("lp_fast_sample_gap", BASE, n);
		host_model_inst.access(1'b1, 8'h2D, 8'h00);
		@(negedge clock_in);
		chk("measure_active", 0, meas);
		repeat (100) @(negedge clock_in);
		rd_chk(8'h0C, mem[2]);
		host_model_inst.access(1'b1, 8'h2D, 8'h08);
		host_model_inst.set_supply(1'b0);
		repeat (4) @(negedge clock_in);
		chk("measure_no_supply", 0, meas);
		host_model_inst.access(1'b0, 8'h2C, 8'h00);
		host_model_inst.set_supply(1'b1);
		repeat (4) @(negedge clock_in);
		chk("measure_supply_back", 1, meas);
		host_model_inst.access(1'b1, 8'h2D, 8'h00);
		repeat (4) @(negedge clock_in);
		chk("pending_reads", 0, exp_q.size());
		final_report();
	end
endmodule
`default_nettype wire
